// ---- fcs_pkg.sv ----
// constants, types and carriers of the flash command sequencer
package fcs_pkg;

  // command data bytes, low eight bits of a bus write cycle
  localparam logic [7:0] FCS_D_AA = 8'haa;
  localparam logic [7:0] FCS_D_55 = 8'h55;
  localparam logic [7:0] FCS_D_F0 = 8'hf0;
  localparam logic [7:0] FCS_D_90 = 8'h90;
  localparam logic [7:0] FCS_D_A0 = 8'ha0;
  localparam logic [7:0] FCS_D_80 = 8'h80;
  localparam logic [7:0] FCS_D_10 = 8'h10;
  localparam logic [7:0] FCS_D_30 = 8'h30;
  localparam logic [7:0] FCS_D_9A = 8'h9a;
  localparam logic [7:0] FCS_D_6A = 8'h6a;
  localparam logic [7:0] FCS_D_00 = 8'h00;

  // command address field: addr[CMD_LSB +: 8]
  localparam int         FCS_CMD_LSB   = 4;
  localparam logic [7:0] FCS_A_55      = 8'h55;
  localparam logic [7:0] FCS_A_AA      = 8'haa;
  localparam int         FCS_ID_LSB    = 2;
  localparam int         FCS_WORD_B    = 4;

  // apb register offsets
  localparam logic [11:0] FCS_OFF_STATUS = 12'h000;
  localparam logic [11:0] FCS_OFF_PROT   = 12'h004;
  localparam logic [11:0] FCS_OFF_SEC    = 12'h008;

  // status register fields
  localparam int FCS_ST_RDY  = 0;
  localparam int FCS_ST_LOCK = 1;
  localparam int FCS_ST_IDM  = 2;

  localparam logic FCS_SEC_RST = 1'b1;

  typedef enum logic [2:0] {
    S_READ = 3'b000,
    S_SEQ  = 3'b001,
    S_PAGE = 3'b010,
    S_ID   = 3'b011,
    S_BUSY = 3'b100,
    S_LOCK = 3'b101
  } fcs_state_e;

  typedef enum logic [1:0] {
    K_ERASE = 2'b00,
    K_PBP   = 2'b01,
    K_PBE   = 2'b10
  } fcs_kind_e;

  typedef enum logic [2:0] {
    OP_PROG   = 3'b000,
    OP_CHIP   = 3'b001,
    OP_BLOCK  = 3'b010,
    OP_PBP    = 3'b011,
    OP_PBE    = 3'b100,
    OP_SECERA = 3'b101
  } fcs_op_e;

  // processor access to the flash area
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fcs_fbreq_s;

endpackage

// ---- fcs_top.sv ----
// flash command sequencer: bus-write decode, automatic operation control, apb status
// Function
// - an operation starts only after every cycle matched in address, data and order
// - a cycle out of order drops the partial command and returns to read mode
// - read and read/reset commands cancel partial sequences and restore read mode
// - read is one write cycle, read/reset three; both restore read mode
// - final cycle starts the operation, flag goes 0; normal end sets 1, read mode
// - new command writes are ignored while an operation runs
// - abnormal end keeps flag at 0 and locks until hardware reset
// - hardware reset aborts a running operation, leaving its result incomplete
// - page program: three command cycles, then page words in address order
// - programming only turns ones into zeros; erase restores ones
// - no internal verify after program or erase
// - program to a protected block leaves it untouched
// - chip erase skips protected blocks; all protected means straight back to read
// - block erase is five cycles plus a block-select cycle; protected is skipped
// - protect program is six cycles plus select cycle; sets that bit to 1
// - protect erase without security clears the selected group of four bits
// - protect erase with security erases all flash then clears all bits
// - identifier query then reads anywhere return the selected code
// - identifier mode stays until a write with data other than 00, or hardware reset
// - after reset and normal completion the array is in read mode
// - only the low eight data bits are decoded as command data
`timescale 1ns/1ps
module fcs_top
  import fcs_pkg::*;
#(
  parameter int          NBLK       = 4,
  parameter int          BLK_LSB    = 15,
  parameter int          PAGE_WORDS = 16,
  parameter logic [3:0]  PROT_INIT  = 4'h0,
  // identifier codes: values are arbitrary
  parameter logic [31:0] ID_MAKER   = 32'h0000_0011,
  parameter logic [31:0] ID_DEVICE  = 32'h0000_0022,
  parameter logic [31:0] ID_MACRO   = 32'h0000_0033,
  parameter logic [31:0] ID_TYPE    = 32'h0000_0044
)(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // processor access to the flash area
  input  wire fcs_fbreq_s            fb_req,
  output logic [31:0]                fb_rdata,
  output logic                       fb_rvalid,
  // flash array macro
  input  wire logic [31:0]           arr_rdata,
  input  wire logic                  arr_done,
  input  wire logic                  arr_fail,
  output logic                       arr_ld,
  output logic [31:0]                arr_ld_addr,
  output logic [31:0]                arr_clr_mask,
  output logic                       arr_start,
  output fcs_op_e                    arr_op,
  output logic [NBLK-1:0]            arr_blk_mask,
  // status
  output logic                       ready_busy_flag
);

  localparam int BW = (NBLK > 1) ? $clog2(NBLK) : 1;
  localparam int PW = $clog2(PAGE_WORDS + 1);

  // parameter checks, refused while elaborating
  if (NBLK < 4 || (NBLK % 4) != 0 || NBLK > 32)
  begin : g_bad_nblk
    $error("NBLK must be a multiple of four up to 32");
  end
  if (PAGE_WORDS < 1)
  begin : g_bad_page
    $error("PAGE_WORDS must be at least one");
  end
  if (BLK_LSB + BW > 32)
  begin : g_bad_blk
    $error("block field must fit inside the address");
  end

  fcs_state_e        state_r, state_nxt;
  fcs_kind_e         kind_r, kind_nxt;
  logic [2:0]        cnt_r, cnt_nxt;
  logic [PW-1:0]     pidx_r, pidx_nxt;
  logic [31:0]       base_r, base_nxt;
  logic [1:0]        idsel_r, idsel_nxt;
  fcs_op_e           op_r, op_nxt;
  logic [BW-1:0]     opblk_r, opblk_nxt;
  logic [NBLK-1:0]   bmask_r, bmask_nxt;
  logic              start_nxt;
  logic              ld_nxt;
  logic [NBLK-1:0]   prot_r;
  logic              sec_r;
  logic [31:0]       ld_addr_r;
  logic [31:0]       clr_mask_r;

  logic              wr;
  logic [7:0]        d8;
  logic [BW-1:0]     wblk;
  logic              a55;
  logic              aaa;

  assign wr   = fb_req.wr;
  assign d8   = fb_req.wdata[7:0];
  assign wblk = fb_req.addr[BLK_LSB +: BW];
  assign a55  = (fb_req.addr[FCS_CMD_LSB +: 8] == FCS_A_55) && (fb_req.addr[1:0] == 2'b00);
  assign aaa  = (fb_req.addr[FCS_CMD_LSB +: 8] == FCS_A_AA) && (fb_req.addr[1:0] == 2'b00);

  // command decode and operation control
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    cnt_nxt   = cnt_r;
    pidx_nxt  = pidx_r;
    base_nxt  = base_r;
    idsel_nxt = idsel_r;
    op_nxt    = op_r;
    opblk_nxt = opblk_r;
    bmask_nxt = bmask_r;
    start_nxt = 1'b0;
    ld_nxt    = 1'b0;
    unique case (state_r)
      S_READ:
      begin
        if (wr && a55 && d8 == FCS_D_AA)
        begin
          state_nxt = S_SEQ;
          cnt_nxt   = 3'd1;
        end
      end
      S_ID:
      begin
        if (wr)
        begin
          if (d8 == FCS_D_00)
            idsel_nxt = fb_req.addr[FCS_ID_LSB +: 2];
          else if (a55 && d8 == FCS_D_AA)
          begin
            state_nxt = S_SEQ;
            cnt_nxt   = 3'd1;
          end
          else
            state_nxt = S_READ;
        end
      end
      S_SEQ:
      begin
        if (wr)
        begin
          state_nxt = S_READ;
          unique case (cnt_r)
            3'd1:
              if (aaa && d8 == FCS_D_55)
              begin
                state_nxt = S_SEQ;
                cnt_nxt   = 3'd2;
              end
            3'd2:
              if (a55)
              begin
                cnt_nxt = 3'd3;
                if (d8 == FCS_D_A0)
                begin
                  state_nxt = S_PAGE;
                  pidx_nxt  = '0;
                end
                else if (d8 == FCS_D_90)
                begin
                  state_nxt = S_ID;
                  idsel_nxt = 2'd0;
                end
                else if (d8 == FCS_D_80)
                begin
                  state_nxt = S_SEQ;
                  kind_nxt  = K_ERASE;
                end
                else if (d8 == FCS_D_9A)
                begin
                  state_nxt = S_SEQ;
                  kind_nxt  = K_PBP;
                end
                else if (d8 == FCS_D_6A)
                begin
                  state_nxt = S_SEQ;
                  kind_nxt  = K_PBE;
                end
              end
            3'd3:
              if (a55 && d8 == FCS_D_AA)
              begin
                state_nxt = S_SEQ;
                cnt_nxt   = 3'd4;
              end
            3'd4:
              if (aaa && d8 == FCS_D_55)
              begin
                state_nxt = S_SEQ;
                cnt_nxt   = 3'd5;
              end
            3'd5:
              if (kind_r == K_ERASE && a55 && d8 == FCS_D_10)
              begin
                op_nxt    = OP_CHIP;
                bmask_nxt = ~prot_r;
                if (~prot_r != '0)
                begin
                  start_nxt = 1'b1;
                  state_nxt = S_BUSY;
                end
              end
              else if (kind_r == K_ERASE && d8 == FCS_D_30)
              begin
                op_nxt    = OP_BLOCK;
                opblk_nxt = wblk;
                bmask_nxt = '0;
                bmask_nxt[wblk] = 1'b1;
                if (!prot_r[wblk])
                begin
                  start_nxt = 1'b1;
                  state_nxt = S_BUSY;
                end
              end
              else if (a55 && ((kind_r == K_PBP && d8 == FCS_D_9A) || (kind_r == K_PBE && d8 == FCS_D_6A)))
              begin
                state_nxt = S_SEQ;
                cnt_nxt   = 3'd6;
              end
            3'd6:
              if ((kind_r == K_PBP && d8 == FCS_D_9A) || (kind_r == K_PBE && d8 == FCS_D_6A))
              begin
                opblk_nxt = wblk;
                bmask_nxt = '0;
                bmask_nxt[wblk] = 1'b1;
                if (kind_r == K_PBP)
                  op_nxt = OP_PBP;
                else if (sec_r)
                begin
                  op_nxt    = OP_SECERA;
                  bmask_nxt = '1;
                end
                else
                  op_nxt = OP_PBE;
                start_nxt = 1'b1;
                state_nxt = S_BUSY;
              end
            default: state_nxt = S_READ;
          endcase
        end
      end
      S_PAGE:
      begin
        if (wr)
        begin
          if (pidx_r != '0 && fb_req.addr != base_r + 32'(pidx_r) * FCS_WORD_B)
            state_nxt = S_READ;
          else
          begin
            if (pidx_r == '0)
            begin
              base_nxt  = fb_req.addr;
              opblk_nxt = wblk;
            end
            ld_nxt   = !prot_r[(pidx_r == '0) ? wblk : opblk_r];
            pidx_nxt = PW'(pidx_r + 1'b1);
            if (pidx_r == PW'(PAGE_WORDS - 1))
            begin
              op_nxt    = OP_PROG;
              bmask_nxt = '0;
              if (prot_r[(pidx_r == '0) ? wblk : opblk_r])
                state_nxt = S_READ;
              else
              begin
                start_nxt = 1'b1;
                state_nxt = S_BUSY;
              end
            end
          end
        end
      end
      S_BUSY:
      begin
        if (arr_fail)
          state_nxt = S_LOCK;
        else if (arr_done)
          state_nxt = S_READ;
      end
      S_LOCK: state_nxt = S_LOCK;
      default: state_nxt = S_READ;
    endcase
  end

  // sequence state; asynchronous reset aborts any operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_READ;
      kind_r  <= K_ERASE;
      cnt_r   <= 3'd0;
      pidx_r  <= '0;
      base_r  <= 32'h0000_0000;
      idsel_r <= 2'd0;
      op_r    <= OP_PROG;
      opblk_r <= '0;
      bmask_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      cnt_r   <= cnt_nxt;
      pidx_r  <= pidx_nxt;
      base_r  <= base_nxt;
      idsel_r <= idsel_nxt;
      op_r    <= op_nxt;
      opblk_r <= opblk_nxt;
      bmask_r <= bmask_nxt;
    end
  end

  // array macro strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arr_ld     <= 1'b0;
      ld_addr_r  <= 32'h0000_0000;
      clr_mask_r <= 32'h0000_0000;
      arr_start  <= 1'b0;
    end
    else
    begin
      arr_ld    <= ld_nxt;
      arr_start <= start_nxt;
      if (ld_nxt)
      begin
        ld_addr_r  <= fb_req.addr;
        clr_mask_r <= ~fb_req.wdata;
      end
    end
  end

  assign arr_ld_addr  = ld_addr_r;
  assign arr_clr_mask = clr_mask_r;
  assign arr_op       = op_r;
  assign arr_blk_mask = bmask_r;

  // protect bits, updated on normal completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prot_r <= NBLK'(PROT_INIT);
    else if (state_r == S_BUSY && arr_done && !arr_fail)
    begin
      for (int i = 0; i < NBLK; i++)
      begin
        if (op_r == OP_PBP && i == int'(opblk_r))
          prot_r[i] <= 1'b1;
        if (op_r == OP_PBE && (i >> 2) == (int'(opblk_r) >> 2))
          prot_r[i] <= 1'b0;
        if (op_r == OP_SECERA)
          prot_r[i] <= 1'b0;
      end
    end
  end

  // ready/busy flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ready_busy_flag <= 1'b1;
    else
      ready_busy_flag <= (state_nxt != S_BUSY) && (state_nxt != S_LOCK);
  end

  // flash area reads: identifier code in identifier mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fb_rdata  <= 32'h0000_0000;
      fb_rvalid <= 1'b0;
    end
    else
    begin
      fb_rvalid <= fb_req.rd;
      if (fb_req.rd)
      begin
        if (state_r == S_ID)
        begin
          unique case (idsel_r)
            2'd0: fb_rdata <= ID_MAKER;
            2'd1: fb_rdata <= ID_DEVICE;
            2'd2: fb_rdata <= ID_MACRO;
            2'd3: fb_rdata <= ID_TYPE;
          endcase
        end
        else
          fb_rdata <= arr_rdata;
      end
    end
  end

  // apb slave: answer in the first access cycle
  logic        apb_setup;
  logic        apb_wr;
  logic [11:0] apb_off;
  logic        apb_hit;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && pready;
  assign apb_off   = paddr[11:0];
  assign apb_hit   = (paddr[31:12] == 20'h00000) &&
                     (apb_off == FCS_OFF_STATUS || apb_off == FCS_OFF_PROT || apb_off == FCS_OFF_SEC);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !apb_hit;
      prdata  <= 32'h0000_0000;
      if (apb_setup && !pwrite)
      begin
        if (apb_off == FCS_OFF_STATUS)
        begin
          prdata[FCS_ST_RDY]  <= ready_busy_flag;
          prdata[FCS_ST_LOCK] <= (state_r == S_LOCK);
          prdata[FCS_ST_IDM]  <= (state_r == S_ID);
        end
        else if (apb_off == FCS_OFF_PROT)
          prdata[NBLK-1:0] <= prot_r;
        else if (apb_off == FCS_OFF_SEC)
          prdata[0] <= sec_r;
      end
    end
  end

  // security setting steers protect erase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sec_r <= FCS_SEC_RST;
    else if (apb_wr && apb_off == FCS_OFF_SEC && paddr[31:12] == 20'h00000)
      sec_r <= pwdata[0];
  end

endmodule

// ---- fcs_arr_model.sv ----
// behavioural flash array facing the sequencer
`timescale 1ns/1ps
module fcs_arr_model
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // sequencer side
  input  wire logic        arr_ld,
  input  wire logic [31:0] arr_ld_addr,
  input  wire logic [31:0] arr_clr_mask,
  input  wire logic        arr_start,
  input  wire fcs_op_e     arr_op,
  input  wire logic [3:0]  arr_blk_mask,
  input  wire logic [31:0] rd_addr,
  output logic [31:0]      arr_rdata,
  output logic             arr_done,
  output logic             arr_fail,
  // bench control: latency and forced failure
  input  wire logic [7:0]  lat,
  input  wire logic        fail_en
);
  logic [31:0] mem [32768];
  logic [7:0]  cnt_r;

  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 32'hffff_ffff;
  end

  assign arr_rdata = mem[rd_addr[16:2]];

  // cells only go 1 to 0 on load; erase restores ones, no verify pass
  always @(posedge pclk)
  begin
    if (arr_ld)
      mem[arr_ld_addr[16:2]] <= mem[arr_ld_addr[16:2]] & ~arr_clr_mask;
    if (arr_start && arr_op inside {OP_CHIP, OP_BLOCK, OP_SECERA})
    begin
      for (int i = 0; i < 32768; i++)
        if (arr_blk_mask[i[14:13]])
          mem[i] = 32'hffff_ffff;
    end
  end

  // reset drops a pending operation
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_r    <= 8'h00;
      arr_done <= 1'b0;
      arr_fail <= 1'b0;
    end
    else
    begin
      arr_done <= 1'b0;
      arr_fail <= 1'b0;
      if (arr_start)
        cnt_r <= lat;
      else if (cnt_r != 8'h00)
      begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          arr_done <= !fail_en;
          arr_fail <= fail_en;
        end
      end
    end
endmodule

// ---- fcs_chk.sv ----
// port assertions of the flash command sequencer
`timescale 1ns/1ps
module fcs_chk
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] paddr,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // flash side
  input  wire fcs_fbreq_s  fb_req,
  input  wire logic        fb_rvalid,
  input  wire logic        arr_start,
  input  wire logic        arr_done,
  input  wire logic        arr_fail,
  input  wire logic        ready_busy_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pready_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  a_pready_alone: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
  a_slverr_map: assert property (psel && !penable |=> pslverr == !($past(paddr) inside {32'h0, 32'h4, 32'h8}))
    else $error("pslverr wrong");
  a_start_busy: assert property (arr_start |-> !ready_busy_flag) else $error("flag high at start");
  a_start_cause: assert property (arr_start |-> $past(fb_req.wr)) else $error("start without write");
  a_done_ready: assert property (arr_done && !arr_fail && !ready_busy_flag |=> ready_busy_flag)
    else $error("flag not set on done");
  a_fail_lock: assert property (arr_fail && !ready_busy_flag |=> !ready_busy_flag [*8])
    else $error("lock released");
  a_rise_cause: assert property ($rose(ready_busy_flag) |-> $past(arr_done)) else $error("flag rose alone");
  a_busy_quiet: assert property (!ready_busy_flag && !arr_start |=> !arr_start) else $error("start while busy");
  a_read_answer: assert property (fb_req.rd |=> fb_rvalid) else $error("no read answer");

  c_start: cover property (arr_start);
  c_fail: cover property (arr_fail);
  c_slverr: cover property (pready && pslverr);
endmodule

bind fcs_top fcs_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .fb_req(fb_req), .fb_rvalid(fb_rvalid),
  .arr_start(arr_start), .arr_done(arr_done), .arr_fail(arr_fail), .ready_busy_flag(ready_busy_flag)
);

// ---- tb_top.sv ----
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
module tb_top;
  import fcs_pkg::*;
  // identifier codes: values are arbitrary
  localparam logic [31:0] IDC [4] = '{32'h11, 32'h22, 32'h33, 32'h44};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, fb_rdata, arr_rdata, arr_ld_addr, arr_clr_mask;
  logic        fb_rvalid, arr_done, arr_fail, arr_ld, arr_start, ready_busy_flag, fail_en;
  fcs_fbreq_s  fb_req;
  fcs_op_e     arr_op;
  logic [3:0]  arr_blk_mask;
  logic [7:0]  lat;
  logic [31:0] pd [16];
  logic [31:0] exp_q [$];
  integer      seed;
  int          n_errors, n_compared;

  fcs_top #(.ID_MAKER(IDC[0]), .ID_DEVICE(IDC[1]), .ID_MACRO(IDC[2]), .ID_TYPE(IDC[3])) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fb_req(fb_req), .fb_rdata(fb_rdata), .fb_rvalid(fb_rvalid), .arr_rdata(arr_rdata),
    .arr_done(arr_done), .arr_fail(arr_fail), .arr_ld(arr_ld), .arr_ld_addr(arr_ld_addr),
    .arr_clr_mask(arr_clr_mask), .arr_start(arr_start), .arr_op(arr_op),
    .arr_blk_mask(arr_blk_mask), .ready_busy_flag(ready_busy_flag));

  fcs_arr_model u_arr (
    .pclk(pclk), .presetn(presetn), .arr_ld(arr_ld), .arr_ld_addr(arr_ld_addr),
    .arr_clr_mask(arr_clr_mask), .arr_start(arr_start), .arr_op(arr_op),
    .arr_blk_mask(arr_blk_mask), .rd_addr(fb_req.addr), .arr_rdata(arr_rdata),
    .arr_done(arr_done), .arr_fail(arr_fail), .lat(lat), .fail_en(fail_en));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic final_report;
    $display("TB counts: compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read results, oldest note first
  always @(posedge pclk)
    if (fb_rvalid === 1'b1 || (pready === 1'b1 && pwrite === 1'b0))
      chk(pready ? prdata : fb_rdata, exp_q.size() ? exp_q.pop_front() : 32'hx);

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    final_report;
  end

  task automatic apb(input logic wr, input logic [11:0] o, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {20'h0, o};
    pwdata  <= d;
    if (!wr)
      exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, err});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fbw(input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    fb_req <= '{1'b1, 1'b0, a, d};
    @(posedge pclk);
    fb_req.wr <= 1'b0;
  endtask

  task automatic fbr(input logic [31:0] a, input logic [31:0] e);
    @(posedge pclk);
    fb_req <= '{1'b0, 1'b1, a, 32'h0};
    exp_q.push_back(e);
    @(posedge pclk);
    fb_req.rd <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    fbw({20'h0, a, 4'h0}, {r[31:8], d});
  endtask

  task automatic hdr(input logic [7:0] c);
    cmd(FCS_A_55, FCS_D_AA);
    cmd(FCS_A_AA, FCS_D_55);
    cmd(FCS_A_55, c);
  endtask

  task automatic five(input logic [7:0] c);
    hdr(c);
    cmd(FCS_A_55, FCS_D_AA);
    cmd(FCS_A_AA, FCS_D_55);
  endtask

  // busy flag seen as expected, then idle again within bound
  task automatic wait_rdy(input logic b);
    int k;
    repeat (2) @(posedge pclk);
    chk({31'h0, ready_busy_flag}, {31'h0, b});
    k = 0;
    while (ready_busy_flag !== 1'b1 && k < 300)
    begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, ready_busy_flag}, 32'h1);
  endtask

  task automatic prot(input logic [7:0] d, input logic [31:0] a);
    five(d);
    cmd(FCS_A_55, d);
    fbw(a, {24'h0, d});
    wait_rdy(1'b0);
  endtask

  task automatic hw_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial
  begin
    seed = 57;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fb_req = '0;
    lat = 8'h04;
    fail_en = 1'b0;
    hw_reset;
    apb(1'b0, FCS_OFF_STATUS, 32'h1, 1'b0);
    apb(1'b0, FCS_OFF_PROT, 32'h0, 1'b0);
    apb(1'b0, FCS_OFF_SEC, 32'h1, 1'b0);
    apb(1'b1, FCS_OFF_STATUS, 32'h0, 1'b0);
    apb(1'b0, FCS_OFF_STATUS, 32'h1, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 1'b1);
    $display("TB test registers done");
    for (int i = 0; i < 16; i++)
      pd[i] = $random(seed);
    pd[7] = 32'hffff_ffff;
    for (int b = 0; b < 2; b++)
    begin
      hdr(FCS_D_A0);
      for (int i = 0; i < 16; i++)
        fbw(32'h100 + b * 32'h8000 + 4 * i, pd[i]);
      wait_rdy(1'b0);
    end
    fbr(32'h100, pd[0]);
    fbr(32'h813c, pd[15]);
    prot(FCS_D_9A, 32'h8000);
    apb(1'b0, FCS_OFF_PROT, 32'h2, 1'b0);
    hdr(FCS_D_A0);
    for (int i = 0; i < 16; i++)
      fbw(32'h8200 + 4 * i, 32'h0);
    wait_rdy(1'b1);
    fbr(32'h8200, 32'hffff_ffff);
    five(FCS_D_80);
    cmd(FCS_A_55, FCS_D_10);
    wait_rdy(1'b0);
    fbr(32'h100, 32'hffff_ffff);
    fbr(32'h8100, pd[0]);
    $display("TB test program and erase done");
    for (int b = 0; b < 4; b++)
      if (b != 1)
        prot(FCS_D_9A, b * 32'h8000);
    apb(1'b0, FCS_OFF_PROT, 32'hf, 1'b0);
    five(FCS_D_80);
    cmd(FCS_A_55, FCS_D_10);
    wait_rdy(1'b1);
    apb(1'b1, FCS_OFF_SEC, 32'h0, 1'b0);
    apb(1'b0, FCS_OFF_SEC, 32'h0, 1'b0);
    prot(FCS_D_6A, 32'h0);
    apb(1'b0, FCS_OFF_PROT, 32'h0, 1'b0);
    $display("TB test protect done");
    hdr(FCS_D_90);
    fbr(32'h200, IDC[0]);
    for (int c = 0; c < 4; c++)
    begin
      fbw(c * 4, 32'h0);
      fbr(32'h300, IDC[c]);
    end
    apb(1'b0, FCS_OFF_STATUS, 32'h5, 1'b0);
    cmd(FCS_A_55, FCS_D_AA);
    cmd(FCS_A_55, FCS_D_55);
    fbr(32'h8100, pd[0]);
    hdr(FCS_D_90);
    fbw(32'h0, {24'h0, FCS_D_F0});
    fbr(32'h8100, pd[0]);
    hdr(FCS_D_90);
    hdr(FCS_D_F0);
    fbr(32'h8100, pd[0]);
    $display("TB test identifier done");
    lat = 8'd40;
    five(FCS_D_80);
    fbw(32'h8000, {24'h0, FCS_D_30});
    five(FCS_D_80);
    cmd(FCS_A_55, FCS_D_10);
    wait_rdy(1'b0);
    repeat (6) @(posedge pclk);
    chk({31'h0, ready_busy_flag}, 32'h1);
    fbr(32'h8100, 32'hffff_ffff);
    five(FCS_D_80);
    cmd(FCS_A_55, FCS_D_10);
    repeat (5) @(posedge pclk);
    hw_reset;
    apb(1'b0, FCS_OFF_STATUS, 32'h1, 1'b0);
    lat = 8'h04;
    fail_en = 1'b1;
    five(FCS_D_80);
    cmd(FCS_A_55, FCS_D_10);
    repeat (20) @(posedge pclk);
    apb(1'b0, FCS_OFF_STATUS, 32'h2, 1'b0);
    cmd(FCS_A_55, FCS_D_F0);
    apb(1'b0, FCS_OFF_STATUS, 32'h2, 1'b0);
    hw_reset;
    fail_en = 1'b0;
    apb(1'b0, FCS_OFF_STATUS, 32'h1, 1'b0);
    $display("TB test abort and lock done");
    repeat (4) @(posedge pclk);
    final_report;
  end
endmodule
